// File: rtl/converter_status_defines.vh
// Purpose: Constants for the converter status register bank
// Assumes: 50 MHz core clock, register bus reached by a simple read/write port
// Notes: Timing counts assume the core clock period below
// Function
// [R1] Thermal trip sets bit 7, cleared by read
// [R2] Bit 6 follows die above 115 C
// [R3] Bit 5: 0 PFM, 1 PWM
// [R4] Bit 4: 0 pass-through, 1 boost
// [R5] Bypass FET limit sets bit 3, read clears
// [R6] Boost limit held 1.5ms sets bit 2
// [R7] Any fault sets bit 1, read clears
// [R8] Bit 0 high while output in range
// [R9] Forced pass-through forces output-in-range to 1
// [R10] Sticky flags survive; events during read kept
// [R11] Reset reads zero; writes have no effect
`ifndef CONVERTER_STATUS_DEFINES_VH
`define CONVERTER_STATUS_DEFINES_VH
`define STATUS_ADDR 8'h05
`define STATUS_RESET 8'h00
`define BIT_THERMAL_TRIP 7
`define BIT_DIE_HOT 6
`define BIT_SWITCHING_SCHEME 5
`define BIT_OPERATING_PATH 4
`define BIT_BYPASS_LIMIT 3
`define BIT_BOOST_LIMIT 2
`define BIT_FAULT 1
`define BIT_OUTPUT_IN_RANGE 0
`define CLK_PERIOD_NS 20
`define BOOST_LIMIT_TIME_US 1500
`define BOOST_LIMIT_CYCLES ((`BOOST_LIMIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`endif

// File: rtl/sync2.v
// Purpose: Two-flop synchroniser for a bus of asynchronous levels
// Assumes: Inputs are quasi-static analog comparator levels
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module sync2 #(
  parameter WIDTH = 8
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;

  // Two stages to settle metastability
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule // sync2

// File: rtl/converter_status.v
// Purpose: Read-only status register with live and clear-on-read bits
// Assumes: Analog status levels arrive asynchronously; bus is core-clock synchronous
// Notes: A read returns data one cycle after rd_en_i; flags clear on that edge
`timescale 1ns/100ps
`include "converter_status_defines.vh"
module converter_status #(
  parameter BOOST_LIMIT_CYCLES = `BOOST_LIMIT_CYCLES
) (
  input wire core_clk_i,
  input wire srst_i,
  input wire thermal_trip_i,
  input wire die_hot_i,
  input wire pwm_active_i,
  input wire boost_path_i,
  input wire forced_bypass_i,
  input wire bypass_limit_i,
  input wire boost_limit_i,
  input wire fault_i,
  input wire output_in_range_i,
  input wire [7:0] addr_i,
  input wire rd_en_i,
  input wire wr_en_i,
  input wire [7:0] wr_data_i,
  output reg [7:0] rd_data_o,
  output reg rd_valid_o,
  output reg [7:0] converter_status_o
);
  wire [8:0] raw_in;
  wire [8:0] sync_in;
  reg [3:0] sticky_reg;
  reg [3:0] sticky_next;
  reg [3:0] event_prev_reg;
  reg [21:0] limit_cnt_reg;
  reg boost_limit_event;
  wire status_read;
  wire [3:0] events;
  wire [3:0] rise;
  wire range_bit;
  wire [7:0] status_now;

  assign raw_in = {output_in_range_i, forced_bypass_i, fault_i, boost_limit_i, bypass_limit_i,
                   boost_path_i, pwm_active_i, die_hot_i, thermal_trip_i};

  // Every analog level is resynchronised before use
  sync2 #(
    .WIDTH(9)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );

  // Boost limit must persist 1.5ms while in boost path
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      limit_cnt_reg <= 22'h000000;
      boost_limit_event <= 1'b0;
    end else begin
      boost_limit_event <= 1'b0;
      // Limit counts only while the boost path is active; one event per episode
      if (sync_in[5] && sync_in[3]) begin // [R6]
        if (limit_cnt_reg == BOOST_LIMIT_CYCLES[21:0] - 22'h000001) begin
          boost_limit_event <= 1'b1;
          limit_cnt_reg <= limit_cnt_reg + 22'h000001;
        end else if (limit_cnt_reg < BOOST_LIMIT_CYCLES[21:0]) begin
          limit_cnt_reg <= limit_cnt_reg + 22'h000001;
        end
      end else begin
        limit_cnt_reg <= 22'h000000;
      end
    end
  end

  // Sticky sources: thermal trip, bypass limit, boost limit, fault
  assign events = {sync_in[0], sync_in[4], 1'b0, sync_in[6]};
  assign rise = {events[3] & ~event_prev_reg[3], events[2] & ~event_prev_reg[2],
                 boost_limit_event, events[0] & ~event_prev_reg[0]};
  assign status_read = rd_en_i && (addr_i == `STATUS_ADDR);

  // Set wins over the read clear so no event is lost
  always @* begin
    sticky_next = sticky_reg;
    if (status_read) begin
      sticky_next = 4'h0; // [R1] [R5] [R6] [R7]
    end
    sticky_next = sticky_next | rise; // [R10]
  end

  // Pass-through forced means range reported good
  assign range_bit = sync_in[8] | sync_in[7]; // [R8] [R9]
  assign status_now = {sticky_reg[3], sync_in[1], sync_in[2], sync_in[3],
                       sticky_reg[2], sticky_reg[1], sticky_reg[0], range_bit}; // [R2] [R3] [R4]

  // Registers and bus answer; writes are ignored
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      sticky_reg <= 4'h0; // [R11]
      event_prev_reg <= 4'h0;
      rd_data_o <= `STATUS_RESET;
      rd_valid_o <= 1'b0;
      converter_status_o <= `STATUS_RESET;
    end else begin
      sticky_reg <= sticky_next;
      event_prev_reg <= events;
      rd_valid_o <= rd_en_i;
      converter_status_o <= status_now;
      if (status_read) begin
        rd_data_o <= status_now;
      end else if (rd_en_i) begin
        rd_data_o <= 8'h00;
      end
    end
  end
endmodule // converter_status

// File: sim/status_host.sv
// Purpose: Host side reader of the status register
// Assumes: Answer comes one cycle after the request edge
// Notes: Address is inverted once idle so stale values never match
`timescale 1ns/100ps
module status_host (
  input wire core_clk_i,
  output reg [7:0] addr_o,
  output reg rd_en_o,
  input wire [7:0] rd_data_i
);
  initial {addr_o, rd_en_o} = 9'h000;
  // One read, driven just after the edge
  task rd(input [7:0] a, output [7:0] d);
    @(posedge core_clk_i) #1 {addr_o, rd_en_o} = {a, 1'b1};
    @(posedge core_clk_i) #1 {addr_o, rd_en_o} = {~a, 1'b0};
    d = rd_data_i;
  endtask
endmodule // status_host

// File: sim/converter_status_checker.sv
// Purpose: Port checks of the status register
// Assumes: One clock domain
// Notes: Bound onto the top module
`timescale 1ns/100ps
module converter_status_checker (
  input wire core_clk_i,
  input wire srst_i,
  input wire rd_en_i,
  input wire [7:0] addr_i,
  input wire die_hot_i,
  input wire pwm_active_i,
  input wire boost_path_i,
  input wire forced_bypass_i,
  input wire [7:0] rd_data_o,
  input wire rd_valid_o,
  input wire [7:0] converter_status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Answer timing and holding of read data
  property p_ans; rd_en_i |=> rd_valid_o ##1 !rd_valid_o || $past(rd_en_i); endproperty
  a_ans: assert property (p_ans) else $error("read answer late");
  property p_hold; !rd_valid_o |-> $stable(rd_data_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; rd_en_i && addr_i != 8'h05 |=> rd_data_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Live bits follow their pins after two sync flops and the output flop
  property p_hot; converter_status_o[6] == $past(die_hot_i, 3); endproperty
  a_hot: assert property (p_hot) else $error("die hot bit wrong");
  property p_pwm; converter_status_o[5] == $past(pwm_active_i, 3); endproperty
  a_pwm: assert property (p_pwm) else $error("switching scheme bit wrong");
  property p_path; converter_status_o[4] == $past(boost_path_i, 3); endproperty
  a_path: assert property (p_path) else $error("operating path bit wrong");
  property p_forced; $past(forced_bypass_i, 3) |-> converter_status_o[0]; endproperty
  a_forced: assert property (p_forced) else $error("forced bypass not in range");
  c_full: cover property (rd_valid_o && rd_data_o == 8'hFF);
  c_live: cover property (rd_valid_o && rd_data_o == 8'h71);
  c_unmap: cover property (rd_en_i && addr_i == 8'h06);
endmodule // converter_status_checker

// File: sim/converter_status_bench.sv
// Purpose: Read sequences against the status register
// Assumes: 50 MHz clock, synchronous reset
// Notes: Boost limit shortened to 20 cycles
`timescale 1ns/100ps
module converter_status_bench;
  reg core_clk_i = 0, srst_i = 1, wr_en_i = 0;
  reg [8:0] src = 9'h000;
  wire [7:0] addr, rd_data;
  wire rd_en;
  reg [7:0] d;
  integer fail_count = 0, n_tests = 0;
  // 20 ns period
  always #10 core_clk_i = ~core_clk_i;
  converter_status #(.BOOST_LIMIT_CYCLES(20)) converter_status_i (.core_clk_i(core_clk_i),
    .srst_i(srst_i), .thermal_trip_i(src[7]), .die_hot_i(src[6]), .pwm_active_i(src[5]),
    .boost_path_i(src[4]), .bypass_limit_i(src[3]), .boost_limit_i(src[2]), .fault_i(src[1]),
    .output_in_range_i(src[0]), .forced_bypass_i(src[8]), .addr_i(addr), .rd_en_i(rd_en),
    .wr_en_i(wr_en_i), .wr_data_i(8'hFF), .rd_data_o(rd_data), .rd_valid_o(),
    .converter_status_o());
  status_host status_host_i (.core_clk_i(core_clk_i), .addr_o(addr), .rd_en_o(rd_en),
    .rd_data_i(rd_data));
  task chk(input [7:0] seen, input [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog, far beyond the roughly 90 cycles needed
  initial begin
    #100000 fail_count = fail_count + 1;
    tally_and_finish;
  end
  // Sources are held levels; sticky bits must not re-set from a held high
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1 srst_i = 0;
    status_host_i.rd(8'h05, d); chk(d, 8'h00);
    wr_en_i = 1;
    @(posedge core_clk_i) #1 wr_en_i = 0;
    src = 9'h071;
    repeat (4) @(posedge core_clk_i);
    status_host_i.rd(8'h05, d); chk(d, 8'h71);
    src = 9'h0FF;
    repeat (30) @(posedge core_clk_i);
    status_host_i.rd(8'h05, d); chk(d, 8'hFF);
    status_host_i.rd(8'h05, d); chk(d, 8'h71);
    src = 9'h16E;
    repeat (30) @(posedge core_clk_i);
    status_host_i.rd(8'h05, d); chk(d, 8'h61);
    // Thermal trip whose synced edge lands on the read edge must survive it
    src = 9'h1EE;
    @(posedge core_clk_i);
    status_host_i.rd(8'h05, d); chk(d, 8'h61);
    status_host_i.rd(8'h05, d); chk(d, 8'hE1);
    status_host_i.rd(8'h05, d); chk(d, 8'h61);
    status_host_i.rd(8'h06, d); chk(d, 8'h00);
    tally_and_finish;
  end
endmodule // converter_status_bench
bind converter_status converter_status_checker converter_status_checker_i (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
  .die_hot_i(die_hot_i), .pwm_active_i(pwm_active_i), .boost_path_i(boost_path_i),
  .forced_bypass_i(forced_bypass_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .converter_status_o(converter_status_o));
